// >>> pcg_clock_gen.sv
// Purpose: clock pulse generator control: run gate, peripheral divide, lock and settle status
// Assumes: core_clk_in is the multiplied internal clock; all inputs synchronous to it
// Notes: system_clock_out and periph_clk_en_out are gate enables for the pad and
//   peripheral clock cells; the analog multiplier itself lives outside this logic
// Functional notes
// - oscillator runs at the applied input frequency, crystal or external
// - internal clock is four times the oscillator frequency
// - system clock pin runs at the internal clock frequency
// - peripheral clock is the internal clock divided by two
// - no fixed phase between input clock and internal clock is assumed
// - all clock generation stops in software and hardware standby
// - crystal resonator or external clock input accepted as source
`timescale 1ns/100ps
module pcg_clock_gen
  import pcg_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYCLES_DFLT,
  parameter int unsigned LOCK_PERIODS = LOCK_PERIODS_DFLT,
  parameter int unsigned PERIOD_W = PERIOD_W_DFLT
)
(
  input wire logic core_clk_in, // internal clock, 40 MHz
  input wire logic reset_n_in, // async reset, active low
  input wire logic ext_clock_in, // external clock or crystal input
  input wire logic crystal_pin, // crystal resonator connection
  input wire logic src_crystal_in, // 1: crystal source, 0: external clock
  input wire logic sw_standby_in, // software standby request
  input wire logic hw_standby_n_in, // hardware standby, active low
  output logic system_clock_out, // system clock pin gate enable
  output logic periph_clk_en_out, // peripheral clock enable, every second cycle
  output pcg_status_t status_out // running, settled, locked
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  generate
    if (SETTLE_CYCLES < 1 || LOCK_PERIODS < 1 || PCLK_DIV != 2)
    begin : g_bad_param
      $error("settle and lock counts must be at least one");
    end
  endgenerate

  localparam int unsigned SETTLE_W = $clog2(SETTLE_CYCLES + 1);
  localparam int unsigned LOCK_W = $clog2(LOCK_PERIODS + 1);
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYCLES - 1);
  localparam logic [LOCK_W-1:0] LOCK_DONE = LOCK_W'(LOCK_PERIODS);
  localparam logic [PERIOD_W-1:0] PERIOD_LOCK = PERIOD_W'(PLL_MULT);

  // ----------------------------------------------------------------
  // oscillator source and period measurement
  // ----------------------------------------------------------------
  logic osc_level;
  logic stop_req;
  logic [PERIOD_W-1:0] period;
  logic period_valid;
  logic osc_stalled;
  pcg_state_t state_r;
  pcg_state_t state_nxt;

  always_comb
  begin
    // source select
    // a crystal drives its connection pin in antiphase to the input pin
    osc_level = src_crystal_in ? ~crystal_pin : ext_clock_in;
    stop_req = sw_standby_in | ~hw_standby_n_in;
  end

  pcg_period_meter #(
    .PERIOD_W(PERIOD_W)
  ) u_meter (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .enable_in(state_r != PCG_ST_STOP),
    .osc_in(osc_level),
    .period_out(period),
    .period_valid_out(period_valid),
    .stalled_out(osc_stalled)
  );

  // ----------------------------------------------------------------
  // run control: stop, settle, run
  // ----------------------------------------------------------------
  logic [SETTLE_W-1:0] settle_cnt_r;
  logic [SETTLE_W-1:0] settle_cnt_nxt;

  always_comb
  begin
    state_nxt = state_r;
    settle_cnt_nxt = settle_cnt_r;
    unique case (state_r)
      PCG_ST_STOP:
      begin
        settle_cnt_nxt = '0;
        if (!stop_req)
        begin
          state_nxt = PCG_ST_SETTLE;
        end
      end
      PCG_ST_SETTLE:
      begin
        settle_cnt_nxt = settle_cnt_r + SETTLE_W'(1);
        if (settle_cnt_r == SETTLE_LAST)
        begin
          state_nxt = PCG_ST_RUN;
        end
      end
      PCG_ST_RUN:
      begin
        settle_cnt_nxt = '0;
      end
    endcase
    if (stop_req)
    begin
      state_nxt = PCG_ST_STOP;
      settle_cnt_nxt = '0;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      // power-on counts as a start: the settling window applies
      state_r <= PCG_ST_SETTLE;
      settle_cnt_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      settle_cnt_r <= settle_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // output clocks and lock status
  // ----------------------------------------------------------------
  logic pclk_phase_r;
  logic pclk_phase_nxt;
  logic sys_nxt;
  logic pclk_en_nxt;
  logic [LOCK_W-1:0] lock_cnt_r;
  logic [LOCK_W-1:0] lock_cnt_nxt;
  pcg_status_t status_nxt;

  always_comb
  begin
    sys_nxt = (state_nxt != PCG_ST_STOP);
    pclk_phase_nxt = sys_nxt ? ~pclk_phase_r : PCLK_PHASE_RST;
    pclk_en_nxt = sys_nxt & pclk_phase_r;
    lock_cnt_nxt = lock_cnt_r;
    if (!sys_nxt || osc_stalled)
    begin
      lock_cnt_nxt = '0;
    end
    else if (period_valid)
    begin
      if (period != PERIOD_LOCK)
      begin
        lock_cnt_nxt = '0;
      end
      else if (lock_cnt_r != LOCK_DONE)
      begin
        lock_cnt_nxt = lock_cnt_r + LOCK_W'(1);
      end
    end
    // lock is reported only, never used to align or gate the clocks
    status_nxt.running = sys_nxt;
    status_nxt.settled = (state_nxt == PCG_ST_RUN);
    status_nxt.locked = (lock_cnt_nxt == LOCK_DONE);
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pclk_phase_r <= PCLK_PHASE_RST;
      system_clock_out <= SYS_CLK_RST;
      periph_clk_en_out <= 1'b0;
      lock_cnt_r <= '0;
      status_out <= '0;
    end
    else
    begin
      pclk_phase_r <= pclk_phase_nxt;
      system_clock_out <= sys_nxt;
      periph_clk_en_out <= pclk_en_nxt;
      lock_cnt_r <= lock_cnt_nxt;
      status_out <= status_nxt;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  property p_ratio_lock;
    (period_valid && period != PERIOD_LOCK) |=> !status_out.locked;
  endproperty
  a_ratio_lock: assert property (p_ratio_lock) else $error("locked with wrong ratio");

  property p_pin_runs;
    (!stop_req && state_r != PCG_ST_STOP) ##1 !stop_req |-> system_clock_out;
  endproperty
  a_pin_runs: assert property (p_pin_runs) else $error("system clock pin not running");

  property p_half_rate;
    system_clock_out ##1 system_clock_out |-> periph_clk_en_out != $past(periph_clk_en_out);
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("peripheral enable not half rate");

  property p_no_phase_dep;
    // a one-cycle standby pulse also drops lock, so the cycle after it is left out
    ($fell(status_out.locked) && !stop_req && !$past(stop_req)) |-> system_clock_out;
  endproperty
  a_no_phase_dep: assert property (p_no_phase_dep) else $error("clock stopped on lock loss");

  property p_standby_stop;
    stop_req |=> (!system_clock_out && !periph_clk_en_out && !status_out.running);
  endproperty
  a_standby_stop: assert property (p_standby_stop) else $error("clock runs in standby");

  property p_settle_wait;
    $rose(system_clock_out) |-> !status_out.settled;
  endproperty
  a_settle_wait: assert property (p_settle_wait) else $error("settled without waiting");

  property p_crystal_src;
    (src_crystal_in && $past(src_crystal_in) && system_clock_out && $past(system_clock_out)
      && !crystal_pin && $past(crystal_pin) && u_meter.count_r != '0)
      |=> period_valid;
  endproperty
  a_crystal_src: assert property (p_crystal_src) else $error("crystal edge not taken");

  property p_pclk_sync;
    periph_clk_en_out |-> (system_clock_out && !$past(periph_clk_en_out));
  endproperty
  a_pclk_sync: assert property (p_pclk_sync) else $error("peripheral enable not aligned");

endmodule : pcg_clock_gen

// >>> pcg_osc_model.sv
// Purpose: oscillator source that feeds the clock pulse generator
// Assumes: levels change 1 ns after a core clock edge
// Notes: the period is set in core cycles, so only whole ratios can be made
`timescale 1ns/100ps
module pcg_osc_model
(
  input wire logic clk_in, // core clock
  input wire logic run_in, // source oscillating
  input wire logic [3:0] half_in, // half period in core cycles
  input wire logic crystal_mode_in, // 1: resonator across both pins
  output logic ext_clock_out, // to ext_clock_in
  output logic crystal_out // to crystal_pin
);
  logic osc_r = 1'b0;
  logic [3:0] cnt_r = 4'h0;

  initial ext_clock_out = 1'b0;
  initial crystal_out = 1'b0;

  // ----------------------------------------------------------------
  // source
  // ----------------------------------------------------------------
  // half period 2..4 gives 10 to 5 MHz, either source kind
  always @(posedge clk_in)
  begin
    #1;
    if (!run_in)
    begin
      osc_r = 1'b0;
      cnt_r = 4'h0;
    end
    else if (4'(cnt_r + 4'h1) >= half_in)
    begin
      osc_r = ~osc_r;
      cnt_r = 4'h0;
    end
    else
      cnt_r = 4'(cnt_r + 4'h1);
    ext_clock_out = osc_r;
    // an open crystal pin must not look stable, so it toggles every cycle
    crystal_out = crystal_mode_in ? ~osc_r : ~crystal_out;
  end
endmodule : pcg_osc_model

// >>> pcg_period_meter.sv
// Purpose: measures the oscillator period in internal clock cycles
// Assumes: osc_in is synchronous to core_clk_in
// Notes: the count saturates, so a stopped oscillator shows as stalled
`timescale 1ns/100ps
module pcg_period_meter
  import pcg_pkg::*;
#(
  parameter int unsigned PERIOD_W = PERIOD_W_DFLT
)
(
  input wire logic core_clk_in, // internal clock
  input wire logic reset_n_in, // async reset, active low
  input wire logic enable_in, // generation running
  input wire logic osc_in, // oscillator level
  output logic [PERIOD_W-1:0] period_out, // last measured period
  output logic period_valid_out, // one-cycle pulse per new period
  output logic stalled_out // no oscillator edge for a full count
);

  generate
    if (PERIOD_W < 3)
    begin : g_bad_width
      $error("period width too small for the x4 ratio");
    end
  endgenerate

  localparam logic [PERIOD_W-1:0] CNT_MAX = {PERIOD_W{1'b1}};
  localparam logic [PERIOD_W-1:0] CNT_ONE = {{(PERIOD_W-1){1'b0}}, 1'b1};

  logic osc_prev_r;
  logic osc_prev_nxt;
  logic [PERIOD_W-1:0] count_r;
  logic [PERIOD_W-1:0] count_nxt;
  logic [PERIOD_W-1:0] period_nxt;
  logic valid_nxt;
  logic stalled_nxt;
  logic osc_rise;

  always_comb
  begin
    osc_rise = osc_in & ~osc_prev_r;
    osc_prev_nxt = osc_in;
    count_nxt = count_r;
    period_nxt = period_out;
    valid_nxt = 1'b0;
    stalled_nxt = 1'b0;
    if (!enable_in)
    begin
      count_nxt = '0;
    end
    else if (osc_rise)
    begin
      // internal periods per oscillator period are counted from each rising edge
      period_nxt = count_r;
      valid_nxt = (count_r != '0);
      count_nxt = CNT_ONE;
    end
    else if (count_r != CNT_MAX)
    begin
      count_nxt = count_r + CNT_ONE;
    end
    else
    begin
      stalled_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      osc_prev_r <= 1'b0;
      count_r <= '0;
      period_out <= '0;
      period_valid_out <= 1'b0;
      stalled_out <= 1'b0;
    end
    else
    begin
      osc_prev_r <= osc_prev_nxt;
      count_r <= count_nxt;
      period_out <= period_nxt;
      period_valid_out <= valid_nxt;
      stalled_out <= stalled_nxt;
    end
  end

  property p_osc_follow;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (enable_in && osc_in && !osc_prev_r && count_r != '0)
      |=> (period_valid_out && period_out == $past(count_r));
  endproperty
  a_osc_follow: assert property (p_osc_follow) else $error("oscillator edge not measured");

endmodule : pcg_period_meter

// >>> pcg_pkg.sv
// Purpose: shared constants and types of the clock pulse generator
// Assumes: the core clock is the multiplied internal clock at 40 MHz
// Notes: settle time is a default only; the top module takes it as a parameter
package pcg_pkg;

  // ----------------------------------------------------------------
  // ratios and timing
  // ----------------------------------------------------------------
  localparam int unsigned PLL_MULT = 4;
  localparam int unsigned PCLK_DIV = 2;
  localparam int unsigned CLK_FREQ_MHZ = 40;
  localparam int unsigned SETTLE_TIME_US = 10000;
  localparam int unsigned SETTLE_CYCLES_DFLT = SETTLE_TIME_US * CLK_FREQ_MHZ;
  localparam int unsigned LOCK_PERIODS_DFLT = 4;
  localparam int unsigned PERIOD_W_DFLT = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic PCLK_PHASE_RST = 1'b0;
  localparam logic SYS_CLK_RST = 1'b0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PCG_ST_STOP,
    PCG_ST_SETTLE,
    PCG_ST_RUN
  } pcg_state_t;

  typedef struct packed {
    logic running;
    logic settled;
    logic locked;
  } pcg_status_t;

endpackage : pcg_pkg

// >>> tb_top.sv
// Purpose: self-checking bench of the clock pulse generator
// Assumes: settle count shortened to 8 cycles
// Notes: outputs are sampled 1 ns after the edge, when edge updates have landed
`timescale 1ns/100ps
module tb_top
  import pcg_pkg::*;
;
  localparam int unsigned SETTLE_SIM = 8;

  logic core_clk_in;
  logic reset_n_in;
  logic ext_clock_in;
  logic crystal_pin;
  logic src_crystal_in;
  logic sw_standby_in;
  logic hw_standby_n_in;
  logic system_clock_out;
  logic periph_clk_en_out;
  pcg_status_t status_out;
  logic osc_run;
  logic [3:0] osc_half;
  int miscompares = 0;
  int comparisons = 0;

  pcg_clock_gen #(.SETTLE_CYCLES(SETTLE_SIM), .LOCK_PERIODS(LOCK_PERIODS_DFLT),
    .PERIOD_W(PERIOD_W_DFLT)) DUT (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .ext_clock_in(ext_clock_in), .crystal_pin(crystal_pin), .src_crystal_in(src_crystal_in),
    .sw_standby_in(sw_standby_in), .hw_standby_n_in(hw_standby_n_in),
    .system_clock_out(system_clock_out), .periph_clk_en_out(periph_clk_en_out),
    .status_out(status_out));

  pcg_osc_model osc (.clk_in(core_clk_in), .run_in(osc_run), .half_in(osc_half),
    .crystal_mode_in(src_crystal_in), .ext_clock_out(ext_clock_in),
    .crystal_out(crystal_pin));

  initial
  begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task step;
    @(posedge core_clk_in);
    #1;
  endtask : step

  task chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk_bit

  task chk_status(input pcg_status_t got, input pcg_status_t exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk_status

  task give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // caller has just released the stop or the reset; settled shows from edge settle_at
  task check_startup(input int settle_at);
    for (int n = 1; n <= SETTLE_SIM + 1; n++)
    begin
      step();
      chk_bit(system_clock_out, 1'b1);
      chk_bit(status_out.running, 1'b1);
      chk_bit(periph_clk_en_out, 1'((n % 2) == 0));
      chk_bit(status_out.settled, 1'(n >= settle_at));
    end
  endtask : check_startup

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task test_standby(input logic use_hw);
    step();
    sw_standby_in = ~use_hw;
    hw_standby_n_in = ~use_hw;
    for (int n = 0; n < 6; n++)
    begin
      step();
      chk_bit(system_clock_out, 1'b0);
      chk_bit(periph_clk_en_out, 1'b0);
      chk_status(status_out, 3'h0);
    end
    sw_standby_in = 1'b0;
    hw_standby_n_in = 1'b1;
    // a standby exit passes through the stop state, one edge more than reset
    check_startup(SETTLE_SIM + 1);
    $display("test standby hw=%0d done", use_hw);
  endtask : test_standby

  // only a period of exactly four core cycles may hold lock
  task test_lock(input logic use_crystal, input logic [3:0] half, input logic exp);
    src_crystal_in = use_crystal;
    osc_half = half;
    osc_run = 1'b1;
    repeat (60) step();
    chk_bit(status_out.locked, exp);
    chk_bit(system_clock_out, 1'b1);
    $display("test lock src=%0d half=%0d done", use_crystal, half);
  endtask : test_lock

  // a stopped source must drop lock after the stall count, yet never stop the clocks
  task test_stall;
    osc_run = 1'b0;
    repeat (270) step();
    chk_bit(status_out.locked, 1'b0);
    chk_bit(system_clock_out, 1'b1);
    $display("test stall done");
  endtask : test_stall

  initial
  begin
    reset_n_in = 1'b0;
    src_crystal_in = 1'b0;
    sw_standby_in = 1'b0;
    hw_standby_n_in = 1'b1;
    osc_run = 1'b0;
    osc_half = 4'h2;
    repeat (12) step();
    reset_n_in = 1'b1;
    // reset enters the settle state directly
    check_startup(SETTLE_SIM);
    $display("test startup done");
    test_lock(1'b0, 4'h2, 1'b1);
    test_lock(1'b0, 4'h3, 1'b0);
    test_lock(1'b0, 4'h4, 1'b0);
    test_lock(1'b1, 4'h2, 1'b1);
    test_stall();
    test_standby(1'b0);
    test_standby(1'b1);
    give_verdict();
  end

  // expected run is under 1000 cycles
  initial
  begin
    #(25 * 3000);
    miscompares++;
    give_verdict();
  end
endmodule : tb_top
